/* hw/irq_trigger_and_vector_unit.sv */
// Purpose: Per-source trigger selection, status and vector generation
// Assumes: Control bus requests held until acknowledged
// Notes:   Vector stays at the base when nothing critical pends
// Functional notes
// - Trigger bit 0 level, 1 edge
// - Timer bits 19-23 freely level or edge
// - External bits 25-31 free; bit 24 reserved
// - Write-only base and order register at 0x0c8
// - Order bit picks bit 31 or 0 first
// - Vectors only for critical-class interrupts
// - Read-only 32-bit vector at 0x0c7
// - Trigger register at 0x0c5, one bit per source
// - Status bit set once its interrupt occurred
`timescale 1ns/100ps
module irq_trigger_and_vector_unit #(
	parameter int NSRC = irq_vec_pkg::NUM_SOURCES
) (
	// Clock and reset
	input  wire logic                            CLK,
	input  wire logic                            RESET_N,
	// Device control register bus
	input  wire logic [irq_vec_pkg::ADDR_W-1:0]  DCR_ADDR,
	input  wire logic                            DCR_READ,
	input  wire logic                            DCR_WRITE,
	input  wire logic [irq_vec_pkg::DATA_W-1:0]  DCR_WR_DATA,
	output logic      [irq_vec_pkg::DATA_W-1:0]  DCR_RD_DATA,
	output logic                                 DCR_ACK,
	// Interrupt sources and class
	input  wire logic [NSRC-1:0]                 SRC_IRQ,
	input  wire logic [NSRC-1:0]                 SRC_ENABLE,
	input  wire logic [NSRC-1:0]                 SRC_CRITICAL,
	input  wire logic [NSRC-1:0]                 STATUS_CLEAR,
	// Status and interrupt outputs
	output logic      [NSRC-1:0]                 IRQ_STATUS,
	output logic                                 CRIT_IRQ,
	output logic                                 NONCRIT_IRQ
);
	import irq_vec_pkg::*;

	if (NSRC != NUM_SOURCES) begin : g_bad_nsrc
		$error("NSRC must equal the 32-bit register layout");
	end

	bus_state_t        bus_state;
	bus_state_t        next_bus_state;
	logic [31:0]       trigger;
	logic [31:0]       next_trigger;
	logic [29:0]       vector_base;
	logic [29:0]       next_vector_base;
	logic              priority_order;
	logic              next_priority_order;
	logic [31:0]       vector;
	logic [31:0]       next_vector;
	logic [31:0]       rd_data;
	logic [31:0]       next_rd_data;
	logic              crit_irq;
	logic              next_crit_irq;
	logic              noncrit_irq;
	logic              next_noncrit_irq;
	logic [31:0]       crit_pend;
	logic [31:0]       noncrit_pend;
	logic [5:0]        pick;
	logic              take;

	function automatic logic [5:0] pick_source(input logic [31:0] pend,
		input logic low_first);
		logic [5:0] r;
		r = 6'h00;
		// Last hit wins, so loop order sets priority
		for (int i = 0; i < 32; i++) begin
			if (low_first) begin
				if (pend[31-i]) r = {1'b1, 5'(31 - i)};
			end else if (pend[i]) begin
				r = {1'b1, 5'(i)};
			end
		end
		return r;
	endfunction : pick_source

	for (genvar g = 0; g < NSRC; g++) begin : g_src
		irq_source_detect u_detect (
			.clk       (CLK),
			.reset_n   (RESET_N),
			.src       (SRC_IRQ[g]),
			.edge_mode (trigger[g]),
			.clear     (STATUS_CLEAR[g]),
			.status    (IRQ_STATUS[g])
		);
	end

	always_comb begin
		take                = (DCR_READ | DCR_WRITE) &&
			bus_state == BUS_IDLE;
		next_bus_state      = take ? BUS_ACK : BUS_IDLE;
		next_trigger        = trigger;
		next_vector_base    = vector_base;
		next_priority_order = priority_order;
		next_rd_data        = rd_data;
		if (take && DCR_WRITE) begin
			case (DCR_ADDR)
				ADDR_TRIGGER: begin
					// Reserved bit 24 never stores
					next_trigger = DCR_WR_DATA & ~TRIG_RSVD_MASK;
				end
				ADDR_VEC_CONFIG: begin
					next_vector_base    = DCR_WR_DATA[BASE_LSB +: BASE_W];
					next_priority_order = DCR_WR_DATA[ORDER_BIT];
				end
				default: begin
				end
			endcase
		end else if (take) begin
			case (DCR_ADDR)
				ADDR_TRIGGER:    next_rd_data = trigger;
				ADDR_VECTOR:     next_rd_data = vector;
				ADDR_VEC_CONFIG: next_rd_data = 32'h0000_0000;
				default:         next_rd_data = 32'h0000_0000;
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			bus_state      <= BUS_IDLE;
			trigger        <= TRIG_RESET;
			vector_base    <= BASE_RESET;
			priority_order <= ORDER_RESET;
			rd_data        <= 32'h0000_0000;
		end else begin
			bus_state      <= next_bus_state;
			trigger        <= next_trigger;
			vector_base    <= next_vector_base;
			priority_order <= next_priority_order;
			rd_data        <= next_rd_data;
		end
	end

	assign DCR_ACK     = (bus_state == BUS_ACK);
	assign DCR_RD_DATA = rd_data;

	// Vector logic; timer and external trigger bits need no special case
	always_comb begin
		crit_pend    = IRQ_STATUS & SRC_ENABLE & SRC_CRITICAL;
		noncrit_pend = IRQ_STATUS & SRC_ENABLE & ~SRC_CRITICAL;
		// Non-critical sources never reach the picker
		pick         = pick_source(crit_pend, priority_order);
		next_vector  = {vector_base, 2'b00};
		if (pick[5]) begin
			next_vector = {vector_base, 2'b00} +
				(32'(pick[4:0]) << VEC_STRIDE_SHIFT);
		end
		next_crit_irq    = |crit_pend;
		next_noncrit_irq = |noncrit_pend;
	end

	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			vector      <= 32'h0000_0000;
			crit_irq    <= 1'b0;
			noncrit_irq <= 1'b0;
		end else begin
			vector      <= next_vector;
			crit_irq    <= next_crit_irq;
			noncrit_irq <= next_noncrit_irq;
		end
	end

	assign CRIT_IRQ    = crit_irq;
	assign NONCRIT_IRQ = noncrit_irq;

	default clocking cb @(posedge CLK); endclocking
	default disable iff (!RESET_N);

	ack_one_cycle_a: assert property (
		DCR_ACK |=> !DCR_ACK)
		else $error("Ack held longer than one cycle");
	trig_write_a: assert property (
		(DCR_WRITE && !DCR_ACK && DCR_ADDR == 10'h0c5) |=>
		trigger == ($past(DCR_WR_DATA) & 32'hfeff_ffff))
		else $error("Trigger write not stored");
	rsvd_bit_a: assert property (
		trigger[24] == 1'b0)
		else $error("Reserved trigger bit set");
	vcr_write_a: assert property (
		(DCR_WRITE && !DCR_ACK && DCR_ADDR == 10'h0c8) |=>
		vector_base == $past(DCR_WR_DATA[29:0]) &&
		priority_order == $past(DCR_WR_DATA[31]))
		else $error("Vector config write not stored");
	vcr_read_a: assert property (
		(DCR_READ && !DCR_WRITE && !DCR_ACK && DCR_ADDR == 10'h0c8) |=>
		DCR_ACK && DCR_RD_DATA == 32'h0000_0000)
		else $error("Write-only register read back data");
	vr_read_a: assert property (
		(DCR_READ && !DCR_WRITE && !DCR_ACK && DCR_ADDR == 10'h0c7) |=>
		DCR_ACK && DCR_RD_DATA == $past(vector))
		else $error("Vector read returned wrong data");
	edge_set_a: assert property (
		(trigger[25] && $rose(SRC_IRQ[25])) |=> IRQ_STATUS[25])
		else $error("Edge event not captured");
	level_hold_a: assert property (
		(!trigger[19] && SRC_IRQ[19]) |=> IRQ_STATUS[19])
		else $error("Level source not held in status");
	no_crit_vec_a: assert property (
		!(|(IRQ_STATUS & SRC_ENABLE & SRC_CRITICAL)) |=>
		vector == {$past(vector_base), 2'b00} && !CRIT_IRQ)
		else $error("Vector generated without critical source");
	order_top_a: assert property (
		(!priority_order && IRQ_STATUS[31] && SRC_ENABLE[31] &&
		SRC_CRITICAL[31]) |=>
		vector == {$past(vector_base), 2'b00} + 32'h0000_03e0)
		else $error("Bit 31 not first with order zero");
	order_low_a: assert property (
		(priority_order && IRQ_STATUS[0] && SRC_ENABLE[0] &&
		SRC_CRITICAL[0]) |=> vector == {$past(vector_base), 2'b00})
		else $error("Bit 0 not first with order one");
	level_clear_a: assert property (
		(!trigger[19] && STATUS_CLEAR[19] && !SRC_IRQ[19]) |=>
		!IRQ_STATUS[19])
		else $error("Level status not cleared");
	req_ack_a: assert property (
		((DCR_READ || DCR_WRITE) && !DCR_ACK) |=> DCR_ACK)
		else $error("Request not acknowledged");
endmodule : irq_trigger_and_vector_unit

/* inc/irq_vec_pkg.sv */
// Purpose: Shared constants for the trigger and vector unit
// Assumes: Index n of every 32-bit vector is the documented bit n
// Notes:   Control bus addresses are word addresses
package irq_vec_pkg;
	localparam int          NUM_SOURCES      = 32;
	localparam int          ADDR_W           = 10;
	localparam int          DATA_W           = 32;
	localparam int          BASE_W           = 30;
	localparam int          BASE_LSB         = 0;
	localparam int          ORDER_BIT        = 31;
	localparam int          VEC_STRIDE_SHIFT = 5;
	localparam logic [9:0]  ADDR_TRIGGER     = 10'h0c5;
	localparam logic [9:0]  ADDR_VECTOR      = 10'h0c7;
	localparam logic [9:0]  ADDR_VEC_CONFIG  = 10'h0c8;
	localparam logic [31:0] TRIG_RSVD_MASK   = 32'h0100_0000;
	localparam logic [31:0] TRIG_RESET       = 32'h0000_0000;
	localparam logic [29:0] BASE_RESET       = 30'h0000_0000;
	localparam logic        ORDER_RESET      = 1'b0;
	localparam logic        TRIG_LEVEL       = 1'b0;
	localparam logic        TRIG_EDGE        = 1'b1;
	typedef enum logic [0:0] {
		BUS_IDLE = 1'b0,
		BUS_ACK  = 1'b1
	} bus_state_t;
endpackage : irq_vec_pkg

/* hw/irq_source_detect.sv */
// Purpose: One interrupt source, level or edge detection into a status bit
// Assumes: Source and clear are synchronous to CLK
// Notes:   A clear in the cycle of a new event loses to the event
`timescale 1ns/100ps
module irq_source_detect (
	// Clock and reset
	input  wire logic clk,
	input  wire logic reset_n,
	// Source side
	input  wire logic src,
	input  wire logic edge_mode,
	input  wire logic clear,
	// Status
	output logic      status
);
	import irq_vec_pkg::*;

	logic prev;
	logic next_prev;
	logic next_status;
	logic event_seen;

	always_comb begin
		next_prev = src;
		if (edge_mode == TRIG_EDGE) begin
			event_seen = src & ~prev;
		end else begin
			event_seen = src;
		end
		// Set beats clear; a live level keeps the bit up
		next_status = (status & ~clear) | event_seen;
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prev   <= 1'b0;
			status <= 1'b0;
		end else begin
			prev   <= next_prev;
			status <= next_status;
		end
	end
endmodule : irq_source_detect

/* tb/core_bus.sv */
// Purpose: Core side of the control bus, one word per access
// Assumes: Request held until acknowledge sampled high
// Notes:   Released address and data lines show the inverse of the last value; strobes go low
`timescale 1ns/100ps
module core_bus (
	// Clock
	input  wire logic                           clk,
	// Control bus
	output logic [irq_vec_pkg::ADDR_W-1:0]      dcr_addr,
	output logic                                dcr_read,
	output logic                                dcr_write,
	output logic [irq_vec_pkg::DATA_W-1:0]      dcr_wr_data,
	input  wire logic [irq_vec_pkg::DATA_W-1:0] dcr_rd_data,
	input  wire logic                           dcr_ack
);
	import irq_vec_pkg::*;
	int timeouts = 0;
	initial begin
		dcr_addr = '0;
		dcr_read = 1'b0;
		dcr_write = 1'b0;
		dcr_wr_data = '0;
	end
	task automatic access(input logic wr, input logic [9:0] a,
		input logic [31:0] d, output logic [31:0] q);
		int n;
		logic [31:0] dd;
		// Software keeps bits 0-18 of the trigger word clear
		dd = d;
		if (a == ADDR_TRIGGER) dd = d & 32'hfff8_0000;
		@(posedge clk);
		dcr_addr <= a;
		dcr_read <= !wr;
		dcr_write <= wr;
		dcr_wr_data <= dd;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (dcr_ack !== 1'b1 && n < 16);
		q = dcr_rd_data;
		// A missing acknowledge must fail the run, not pass silently
		if (dcr_ack !== 1'b1) begin
			timeouts++;
			$display("Error bus ack expected 1 seen %b", dcr_ack);
		end
		dcr_read <= 1'b0;
		dcr_write <= 1'b0;
		// Stale values would hide a missed address or data latch
		dcr_addr <= ~a;
		dcr_wr_data <= ~dd;
	endtask : access
endmodule : core_bus

/* tb/tb.sv */
// Purpose: Self-checking bench of the trigger and vector unit
// Assumes: All sources level except where a test selects edge
// Notes:   Inputs change only by non-blocking assignment at CLK
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin \
	errors++; \
	$display("Error %s expected %h seen %h", nm, e, g); \
	end end
module tb;
	import irq_vec_pkg::*;
	logic        CLK, RESET_N, DCR_READ, DCR_WRITE, DCR_ACK;
	logic        CRIT_IRQ, NONCRIT_IRQ, ord;
	logic [9:0]  DCR_ADDR;
	logic [31:0] DCR_WR_DATA, DCR_RD_DATA, SRC_IRQ, SRC_ENABLE;
	logic [31:0] SRC_CRITICAL, STATUS_CLEAR, IRQ_STATUS, q, p, en, cr, t;
	logic [29:0] base;
	int          errors, checks_done, seed;
	irq_trigger_and_vector_unit irq_trigger_and_vector_unit_i (
		.CLK(CLK), .RESET_N(RESET_N), .DCR_ADDR(DCR_ADDR),
		.DCR_READ(DCR_READ), .DCR_WRITE(DCR_WRITE),
		.DCR_WR_DATA(DCR_WR_DATA), .DCR_RD_DATA(DCR_RD_DATA),
		.DCR_ACK(DCR_ACK), .SRC_IRQ(SRC_IRQ), .SRC_ENABLE(SRC_ENABLE),
		.SRC_CRITICAL(SRC_CRITICAL), .STATUS_CLEAR(STATUS_CLEAR),
		.IRQ_STATUS(IRQ_STATUS), .CRIT_IRQ(CRIT_IRQ),
		.NONCRIT_IRQ(NONCRIT_IRQ));
	core_bus core_bus_i (.clk(CLK), .dcr_addr(DCR_ADDR),
		.dcr_read(DCR_READ), .dcr_write(DCR_WRITE),
		.dcr_wr_data(DCR_WR_DATA), .dcr_rd_data(DCR_RD_DATA),
		.dcr_ack(DCR_ACK));
	function automatic logic [31:0] exp_vec(logic [29:0] b, logic o,
		logic [31:0] pend);
		int w;
		w = -1;
		for (int i = 0; i < 32; i++) begin
			if (pend[o ? 31 - i : i]) w = o ? 31 - i : i;
		end
		if (w < 0) return {b, 2'b00};
		return {b, 2'b00} + (32'(w) << VEC_STRIDE_SHIFT);
	endfunction : exp_vec
	task automatic stop_test;
		errors += core_bus_i.timeouts;
		$display("Checks %0d errors %0d", checks_done, errors);
		if (errors == 0 && checks_done > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask : stop_test
	task automatic clear_all;
		SRC_IRQ <= '0;
		STATUS_CLEAR <= '1;
		@(posedge CLK);
		STATUS_CLEAR <= '0;
	endtask : clear_all
	initial begin
		CLK = 1'b0;
		forever #2.5 CLK = ~CLK;
	end
	initial begin
		repeat (20000) @(posedge CLK);
		errors++;
		stop_test();
	end
	initial begin
		seed = 12590;
		errors = 0;
		checks_done = 0;
		RESET_N = 1'b0;
		SRC_IRQ = '0;
		SRC_ENABLE = '0;
		SRC_CRITICAL = '0;
		STATUS_CLEAR = '0;
		repeat (20) @(posedge CLK);
		RESET_N <= 1'b1;
		core_bus_i.access(1'b0, ADDR_TRIGGER, '0, q);
		`CHK("trigger reset", TRIG_RESET, q)
		t = $random(seed);
		core_bus_i.access(1'b1, ADDR_TRIGGER, t, q);
		core_bus_i.access(1'b0, ADDR_TRIGGER, '0, q);
		t = t & 32'hfff8_0000 & ~TRIG_RSVD_MASK;
		`CHK("trigger", t, q)
		core_bus_i.access(1'b1, ADDR_VECTOR, '1, q);
		core_bus_i.access(1'b0, ADDR_VECTOR, '0, q);
		`CHK("vector read-only", 32'h0000_0000, q)
		core_bus_i.access(1'b1, 10'h3ff, '1, q);
		core_bus_i.access(1'b0, 10'h3ff, '0, q);
		`CHK("unmapped", 32'h0000_0000, q)
		core_bus_i.access(1'b0, ADDR_VEC_CONFIG, '0, q);
		`CHK("config write-only", 32'h0000_0000, q)
		core_bus_i.access(1'b1, ADDR_TRIGGER, '0, q);
		// First two passes: both end bits pending, one per order
		for (int k = 0; k < 12; k++) begin
			base = 30'($random(seed));
			ord = k[0];
			p = (k < 2) ? 32'h8000_0001 : $random(seed);
			en = (k < 2) ? '1 : $random(seed);
			cr = (k < 2) ? '1 : (k == 3) ? '0 : $random(seed);
			core_bus_i.access(1'b1, ADDR_VEC_CONFIG, {ord, 1'b0, base}, q);
			SRC_IRQ <= p;
			SRC_ENABLE <= en;
			SRC_CRITICAL <= cr;
			repeat (4) @(posedge CLK);
			`CHK("status", p, IRQ_STATUS)
			`CHK("critical", |(p & en & cr), CRIT_IRQ)
			`CHK("non-critical", |(p & en & ~cr), NONCRIT_IRQ)
			core_bus_i.access(1'b0, ADDR_VECTOR, '0, q);
			t = exp_vec(base, ord, p & en & cr);
			`CHK("vector", t, q)
			clear_all();
		end
		// Timer 0 and external request 0, each mode on each
		for (int m = 0; m < 2; m++) begin
			t = m ? 32'h0008_0000 : 32'h0200_0000;
			core_bus_i.access(1'b1, ADDR_TRIGGER, t, q);
			SRC_IRQ <= 32'h0208_0000;
			repeat (3) @(posedge CLK);
			`CHK("both set", 32'h0208_0000, IRQ_STATUS)
			STATUS_CLEAR <= '1;
			@(posedge CLK);
			STATUS_CLEAR <= '0;
			repeat (2) @(posedge CLK);
			p = ~t & 32'h0208_0000;
			`CHK("after clear", p, IRQ_STATUS)
			// A new edge in the cycle of a clear must win
			SRC_IRQ <= '0;
			@(posedge CLK);
			SRC_IRQ <= 32'h0208_0000;
			STATUS_CLEAR <= '1;
			@(posedge CLK);
			STATUS_CLEAR <= '0;
			@(posedge CLK);
			`CHK("set beats clear", 32'h0208_0000, IRQ_STATUS)
			clear_all();
			repeat (2) @(posedge CLK);
		end
		stop_test();
	end
endmodule : tb
